// [hdl/result_fifo_pkg.sv]
// Constants shared by the result buffer and its item sequencer.
// Assumes an 8-bit register address space reached through a register pointer.
package result_fifo_pkg;

  // ***************************************************************
  // Register addresses and reset values
  // ***************************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'hDF;
  localparam logic [7:0] ADDR_MAP = 8'hFC;
  localparam logic [7:0] ADDR_LEVEL = 8'hFD;
  localparam logic [7:0] ADDR_DATA_LOW = 8'hFE;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'hFF;
  localparam logic [7:0] CONFIG_RESET = 8'h21;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] MAP_WRITE_MASK = 8'h7F;

  // ***************************************************************
  // Field positions and sizes
  // ***************************************************************
  localparam int CFG_FLICKER_BIT = 7;
  localparam int MAP_STATUS_BIT = 0;
  localparam int MAP_CH0_BIT = 1;
  localparam int MAP_CH5_BIT = 6;
  localparam int ITEM_FLICKER = 7;
  localparam int ITEM_COUNT = 8;
  localparam int CHANNELS = 6;
  localparam int DEPTH = 128;
  localparam int LEVEL_W = 8;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage

// [hdl/item_sequencer.sv]
// Steps through all eight items of one measurement cycle, one per clock, pushing the enabled ones.
// Assumes start is a one-cycle pulse from logic on clk_sys.
`timescale 1ns/1ps
module item_sequencer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] enables,
  input wire logic [7:0] status_byte,
  input wire logic [5:0][15:0] channel_data,
  input wire logic [7:0] flicker_byte,
  output logic push,
  output logic [15:0] push_data,
  output logic busy
);

  // ***************************************************************
  // Item selection
  // ***************************************************************
  logic busy_r;
  logic [2:0] idx_r;
  logic [7:0] en_r;
  logic [7:0] status_r;
  logic [5:0][15:0] chan_r;
  logic [7:0] flick_r;
  logic push_r;
  logic [15:0] push_data_r;
  logic [15:0] item_word;
  logic last_item;

  // Index 0 is the status byte, 1 to 6 the channels, 7 the flicker byte.
  function automatic logic [15:0] pick(input logic [2:0] i,
      input logic [7:0] st, input logic [5:0][15:0] ch,
      input logic [7:0] fl);
    logic [15:0] w;
    w = {result_fifo_pkg::ZERO_BYTE, st};
    if (i == 3'(result_fifo_pkg::ITEM_FLICKER)) begin
      w = {result_fifo_pkg::ZERO_BYTE, fl};
    end else if (i != 3'(result_fifo_pkg::MAP_STATUS_BIT)) begin
      w = ch[3'(i - 3'(result_fifo_pkg::MAP_CH0_BIT))];
    end
    return w;
  endfunction

  assign item_word = pick(idx_r, status_r, chan_r, flick_r);
  assign last_item = idx_r == 3'(result_fifo_pkg::ITEM_COUNT - 1);
  assign push = push_r;
  assign push_data = push_data_r;
  assign busy = busy_r;

  // ***************************************************************
  // Sequencing
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      idx_r <= 3'h0;
      en_r <= 8'h00;
      status_r <= 8'h00;
      chan_r <= '0;
      flick_r <= 8'h00;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      idx_r <= 3'h0;
      en_r <= enables;
      status_r <= status_byte;
      chan_r <= channel_data;
      flick_r <= flicker_byte;
    end else if (busy_r) begin
      idx_r <= 3'(idx_r + 3'h1); // [R14]
      busy_r <= !last_item;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      push_r <= 1'b0;
      push_data_r <= 16'h0000;
    end else begin
      push_r <= busy_r && en_r[idx_r]; // [R9] [R10] [R12]
      push_data_r <= item_word;
    end
  end

  AST_ONE_PASS: assert property (@(posedge clk_sys) disable iff (!rstn)
      start && !busy_r |=> busy_r [*8] ##1 !busy_r) // [R14]
    else $error("Sequencer pass did not take eight cycles.");

endmodule

// [hdl/spectral_result_fifo.sv]
// Readout buffer for measurement results, reached through a register pointer.
// Assumes the serial bus controller and producer run on clk_sys.
// What this block does
// [R1] Holds queued results in 128 entries of two bytes each.
// [R2] An item arriving with all 128 entries unread sets overflow, is dropped.
// [R3] Register pointer wraps from the upper data address back to the lower.
// [R4] Reading the upper data address pops one entry and lowers the level.
// [R5] Burst reads pop exactly once per two-byte entry consumed.
// [R6] Data addresses read zero while the level is zero.
// [R7] Buffer interrupt is high while unread data is held.
// [R8] Read-only fill level, 0 to 128 entries, at its own address.
// [R9] Map bits 1 to 6 queue channels 0 to 5, two bytes each.
// [R10] Map bit 0 queues the status byte as one two-byte entry, upper byte zero.
// [R11] Channel 5 enable is ignored while flicker detection is on.
// [R12] Config bit 7 queues flicker bytes only while flicker detection is on.
// [R13] Host keeps the reserved config bits at their default pattern.
// [R14] Items of one cycle enter in ascending map bit order.
`timescale 1ns/1ps
module spectral_result_fifo #(
  parameter int DEPTH = result_fifo_pkg::DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ptr_load,
  input wire logic [7:0] ptr_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] reg_ptr,
  input wire logic meas_valid,
  input wire logic [7:0] measurement_status_byte,
  input wire logic [5:0][15:0] channel_data,
  input wire logic [7:0] flicker_byte,
  input wire logic flicker_detect_enable,
  input wire logic overflow_clear,
  output logic overflow_flag,
  output logic buffer_data_irq,
  output logic seq_busy
);

  localparam int AW = $clog2(DEPTH);
  localparam int LW = result_fifo_pkg::LEVEL_W;
  localparam logic [LW-1:0] LEVEL_FULL = LW'(DEPTH);
  localparam logic [LW-1:0] LEVEL_EMPTY = LW'(0);

  // ***************************************************************
  // Registers and storage
  // ***************************************************************
  logic [7:0] ptr_r;
  logic [7:0] buffer_config_r;
  logic [7:0] buffer_source_select_r;
  logic [LW-1:0] buffer_fill_count_r;
  logic [LW-1:0] level_nxt;
  logic [AW-1:0] rd_idx_r;
  logic [AW-1:0] wr_idx_r;
  logic [15:0] store_r [DEPTH];
  logic overflow_r;
  logic [7:0] rdata_r;

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    return (p == result_fifo_pkg::ADDR_DATA_HIGH) ?
        result_fifo_pkg::ADDR_DATA_LOW : 8'(p + 8'h01);
  endfunction

  // ***************************************************************
  // Decoding
  // ***************************************************************
  wire level_zero = buffer_fill_count_r == LEVEL_EMPTY;
  wire full = buffer_fill_count_r == LEVEL_FULL;
  wire rd_go = reg_rd && !ptr_load;
  wire wr_go = reg_wr && !ptr_load && !reg_rd;
  wire at_low = ptr_r == result_fifo_pkg::ADDR_DATA_LOW;
  wire at_high = ptr_r == result_fifo_pkg::ADDR_DATA_HIGH;
  wire pop = rd_go && at_high && !level_zero; // [R4] [R5]
  wire push;
  wire [15:0] push_data;
  wire accept = push && !full; // [R2]
  wire reject = push && full; // [R2]
  wire [15:0] head_word = level_zero ? 16'h0000 : store_r[rd_idx_r]; // [R6]
  wire [7:0] map_rd = buffer_source_select_r &
      result_fifo_pkg::MAP_WRITE_MASK;
  wire [7:0] rd_value =
      at_low ? head_word[7:0] :
      at_high ? head_word[15:8] :
      (ptr_r == result_fifo_pkg::ADDR_LEVEL) ? buffer_fill_count_r :
      (ptr_r == result_fifo_pkg::ADDR_MAP) ? map_rd :
      (ptr_r == result_fifo_pkg::ADDR_CONFIG) ? buffer_config_r : 8'h00;

  wire ch5_en = buffer_source_select_r[result_fifo_pkg::MAP_CH5_BIT] &&
      !flicker_detect_enable; // [R11]
  wire flick_en = buffer_config_r[result_fifo_pkg::CFG_FLICKER_BIT] &&
      flicker_detect_enable; // [R12]
  wire [7:0] enables = {flick_en, ch5_en,
      buffer_source_select_r[result_fifo_pkg::MAP_CH5_BIT-1:0]}; // [R9] [R10]

  assign level_nxt = LW'(buffer_fill_count_r + LW'(accept) - LW'(pop));
  assign reg_rdata = rdata_r;
  assign reg_ptr = ptr_r;
  assign overflow_flag = overflow_r;
  assign buffer_data_irq = !level_zero; // [R7]

  // ***************************************************************
  // Item sequencer
  // ***************************************************************
  item_sequencer u_seq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(meas_valid),
    .enables(enables),
    .status_byte(measurement_status_byte),
    .channel_data(channel_data),
    .flicker_byte(flicker_byte),
    .push(push),
    .push_data(push_data),
    .busy(seq_busy)
  );

  // ***************************************************************
  // Register port
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= 8'h00;
      rdata_r <= 8'h00;
    end else if (ptr_load) begin
      ptr_r <= ptr_addr;
    end else if (rd_go || wr_go) begin
      ptr_r <= next_ptr(ptr_r); // [R3]
      if (rd_go) begin
        rdata_r <= rd_value;
      end
    end
  end

  // The reserved config bits are stored as written; the host keeps them.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      buffer_config_r <= result_fifo_pkg::CONFIG_RESET;
      buffer_source_select_r <= result_fifo_pkg::MAP_RESET;
    end else if (wr_go) begin
      if (ptr_r == result_fifo_pkg::ADDR_CONFIG) begin
        buffer_config_r <= reg_wdata; // [R13]
      end
      if (ptr_r == result_fifo_pkg::ADDR_MAP) begin
        buffer_source_select_r <= reg_wdata & result_fifo_pkg::MAP_WRITE_MASK;
      end
    end
  end

  // ***************************************************************
  // Buffer pointers and level
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_idx_r <= '0;
      wr_idx_r <= '0;
      buffer_fill_count_r <= LEVEL_EMPTY;
      overflow_r <= 1'b0;
    end else begin
      buffer_fill_count_r <= level_nxt; // [R8]
      if (pop) begin
        rd_idx_r <= AW'(rd_idx_r + 1'b1); // [R4]
      end
      if (accept) begin
        wr_idx_r <= AW'(wr_idx_r + 1'b1);
      end
      // A drop in the clearing cycle still leaves the flag set.
      if (reject) begin
        overflow_r <= 1'b1; // [R2]
      end else if (overflow_clear) begin
        overflow_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (accept) begin
      store_r[wr_idx_r] <= push_data; // [R1]
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  AST_POP_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstn)
      pop && !accept |=> buffer_fill_count_r ==
      LW'($past(buffer_fill_count_r) - 1'b1)) // [R4]
    else $error("Upper data read did not lower the level by one.");

  AST_LOW_NO_POP: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_go && at_low && !push |=> $stable(buffer_fill_count_r) &&
      $stable(rd_idx_r)) // [R5]
    else $error("Lower data read consumed an entry.");

  AST_PTR_WRAP: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_go && at_high |=> ptr_r == result_fifo_pkg::ADDR_DATA_LOW ##1
      1'b1) // [R3]
    else $error("Pointer did not wrap to the lower data address.");

  AST_OVERFLOW: assert property (@(posedge clk_sys) disable iff (!rstn)
      push && full && !pop |=> overflow_r &&
      buffer_fill_count_r == LEVEL_FULL && $stable(wr_idx_r)) // [R2]
    else $error("Item arriving at full level was not dropped.");

  AST_EMPTY_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_go && level_zero && (at_low || at_high) |=>
      rdata_r == 8'h00) // [R6]
    else $error("Data read at zero level was not zero.");

  AST_IRQ_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rstn)
      level_zero && push |=> buffer_data_irq) // [R7]
    else $error("Interrupt not raised after data entered.");

  AST_LEVEL_RANGE: assert property (@(posedge clk_sys) disable iff (!rstn)
      buffer_fill_count_r <= LEVEL_FULL) // [R8]
    else $error("Fill level above the buffer depth.");

  AST_LEVEL_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_go && ptr_r == result_fifo_pkg::ADDR_LEVEL |=>
      rdata_r == $past(buffer_fill_count_r)) // [R8]
    else $error("Level read returned a wrong value.");

  AST_CH5_MASK: assert property (@(posedge clk_sys) disable iff (!rstn)
      flicker_detect_enable |-> !enables[result_fifo_pkg::MAP_CH5_BIT] &&
      (enables[result_fifo_pkg::ITEM_FLICKER] ==
      buffer_config_r[result_fifo_pkg::CFG_FLICKER_BIT])) // [R11] [R12]
    else $error("Flicker mode enables are wrong.");

  AST_FIFO_ORDER: assert property (@(posedge clk_sys) disable iff (!rstn)
      level_zero && accept && !pop ##1 rd_go && at_low |=>
      rdata_r == $past(push_data[7:0], 2)) // [R1]
    else $error("Head entry differs from first stored item.");

endmodule

// [dv/meas_source.sv]
// Measurement source model that feeds the producer side of the result buffer.
// Assumes go is a one-cycle pulse from the bench on clk_sys.
`timescale 1ns/1ps
module meas_source (
  input wire logic clk_sys,
  input wire logic go,
  output logic meas_valid,
  output logic [7:0] status_out,
  output logic [5:0][15:0] chan_out,
  output logic [7:0] flicker_out
);
  // ***************************************************************
  // Result pattern, inverted outside the valid cycle
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    meas_valid <= go;
  end

  // The lines carry the inverse when not valid, so late sampling shows up.
  always_comb begin
    status_out = meas_valid ? 8'h5A : 8'hA5;
    flicker_out = meas_valid ? 8'h3C : 8'hC3;
    for (int i = 0; i < 6; i++) begin
      chan_out[i] = {8'hC0 | 8'(i), 8'h10 | 8'(i)};
      if (!meas_valid) begin
        chan_out[i] = ~chan_out[i];
      end
    end
  end
endmodule

// [dv/spectral_result_fifo_test.sv]
// Self-checking bench for the result buffer, driven through its register port.
// Assumes the measurement source model drives the producer inputs.
`timescale 1ns/1ps
module spectral_result_fifo_test;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ptr_load = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, go = 1'b0;
  logic [7:0] ptr_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, reg_ptr;
  logic flicker_on = 1'b0, ovf_clr = 1'b0;
  logic meas_valid, overflow_flag, irq, seq_busy;
  logic [7:0] st_b, fl_b;
  logic [5:0][15:0] ch_d;
  logic [15:0] q[$];
  int mismatches = 0;
  int n_checks = 0;

  always #10 clk_sys = ~clk_sys;

  spectral_result_fifo DUT (.clk_sys(clk_sys), .rstn(rstn),
    .ptr_load(ptr_load), .ptr_addr(ptr_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ptr(reg_ptr), .meas_valid(meas_valid),
    .measurement_status_byte(st_b), .channel_data(ch_d),
    .flicker_byte(fl_b), .flicker_detect_enable(flicker_on),
    .overflow_clear(ovf_clr), .overflow_flag(overflow_flag),
    .buffer_data_irq(irq), .seq_busy(seq_busy));

  meas_source src (.clk_sys(clk_sys), .go(go), .meas_valid(meas_valid),
    .status_out(st_b), .chan_out(ch_d), .flicker_out(fl_b));

  // ***************************************************************
  // Access tasks
  // ***************************************************************
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ld(input logic [7:0] a);
    @(posedge clk_sys) ptr_load <= 1'b1;
    ptr_addr <= a;
    @(posedge clk_sys) ptr_load <= 1'b0;
  endtask

  task automatic rdn(input logic [7:0] exp);
    @(posedge clk_sys) reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    ld(a);
    rdn(exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ld(a);
    @(posedge clk_sys) reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask

  task automatic meas;
    int k;
    @(posedge clk_sys) go <= 1'b1;
    @(posedge clk_sys) go <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    // Busy is looked at after the edge has settled, never in its time step.
    for (k = 0; k < 20 && seq_busy !== 1'b0; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (k == 20) begin
      mismatches++;
      $display("[ERR] %0t sequencer stuck busy", $time);
      end_sim();
    end
    repeat (4) @(posedge clk_sys);
  endtask

  // Reads every queued entry low byte first, then checks the pointer wrap.
  task automatic drain;
    ld(8'hFE);
    foreach (q[k]) begin
      rdn(q[k][7:0]);
      rdn(q[k][15:8]);
    end
    chk(reg_ptr, 8'hFE);
    q.delete();
  endtask

  function automatic logic [15:0] chw(input int i);
    return {8'hC0 | 8'(i), 8'h10 | 8'(i)};
  endfunction

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'hDF, 8'h21);
    rd(8'hFC, 8'h00);
    rd(8'hFD, 8'h00);
    rd(8'hFE, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("Test reset values done");
    wr(8'hFC, 8'hFF);
    rd(8'hFC, 8'h7F);
    wr(8'hDF, 8'hA1);
    meas();
    rd(8'hFD, 8'h07);
    chk({7'h00, irq}, 8'h01);
    q = {16'h005A, chw(0), chw(1), chw(2), chw(3), chw(4), chw(5)};
    drain();
    rd(8'hFD, 8'h00);
    rd(8'hFF, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("Test all sources done");
    @(posedge clk_sys) flicker_on <= 1'b1;
    meas();
    rd(8'hFD, 8'h07);
    q = {16'h005A, chw(0), chw(1), chw(2), chw(3), chw(4), 16'h003C};
    drain();
    wr(8'hDF, 8'h21);
    meas();
    rd(8'hFD, 8'h06);
    q = {16'h005A, chw(0), chw(1), chw(2), chw(3), chw(4)};
    drain();
    $display("Test flicker done");
    @(posedge clk_sys) flicker_on <= 1'b0;
    wr(8'hFC, 8'h02);
    repeat (129) meas();
    rd(8'hFD, 8'h80);
    chk({7'h00, overflow_flag}, 8'h01);
    rd(8'hFE, 8'h10);
    rd(8'hFD, 8'h80);
    rd(8'hFF, 8'hC0);
    rd(8'hFD, 8'h7F);
    @(posedge clk_sys) ovf_clr <= 1'b1;
    @(posedge clk_sys) ovf_clr <= 1'b0;
    @(posedge clk_sys);
    #1 chk({7'h00, overflow_flag}, 8'h00);
    repeat (127) q.push_back(chw(0));
    drain();
    rd(8'hFD, 8'h00);
    $display("Test overflow done");
    // The low byte is read in the cycle right after the only item lands.
    ld(8'hFE);
    @(posedge clk_sys) go <= 1'b1;
    @(posedge clk_sys) go <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdn(8'h10);
    rdn(8'hC0);
    rd(8'hFD, 8'h00);
    $display("Test read during push done");
    end_sim();
  end
endmodule
